// ===== gauge_status_pkg.sv
// Constants shared by the gauge status readout and its shift register.
// Assumes a single 10 MHz clock and a synchronous, active-high reset.
package gauge_status_pkg;

  // Word and frame geometry.
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned ACC_W      = 15;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned SEL_W      = 4;

  // Positions of the status select field inside a received command word.
  localparam int unsigned SEL_HI     = 11;
  localparam int unsigned SEL_LO     = 8;

  // Command address carried in the top bits of a received word.
  localparam int unsigned ADDR_HI    = 15;
  localparam int unsigned ADDR_LO    = 13;
  localparam logic [2:0]  ADDR_GAUGE_CFG = 3'h0;

  // Gauge enable bits inside the gauge configuration command.
  localparam int unsigned CFG_EN0    = 0;
  localparam int unsigned CFG_EN1    = 4;

  // Values after reset.
  localparam logic [SEL_W-1:0]  SEL_RESET = 4'h0;
  localparam logic [ACC_W-1:0]  ACC_RESET = 15'h0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  // Idle levels of the synchronised pins, chip select first: only chip select idles high.
  localparam logic [13:0]       SYNC_IDLE = 14'h2000;

  // Select codes for the other word types.
  localparam logic [SEL_W-1:0] SEL_POS0 = 4'hc;
  localparam logic [SEL_W-1:0] SEL_POS1 = 4'hd;

  // Frame engine states, gray coded along idle, active, close.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_CLOSE  = 2'b11
  } frame_state_e;

endpackage

// ===== gauge_status_readout.sv
// Status readout of a dual step-motor gauge driver: selects, builds and shifts
// out the status word, and keeps the sticky fault and movement flags.
// Assumes the host is the serial master; all pins are asynchronous to mclk.
//
// How it works
// - The status select field only changes on a valid gauge config write or reset.
// - Select bit 11 low picks the device status word.
// - Select bits 11:10 equal to 10 pick the accumulator word.
// - Status bits 15 and 14 show gauge 1 and gauge 0 direction.
// - Status bits 13 and 12 show each gauge's configured zero side.
// - Status bits 11 and 10 read 1 while a gauge is off target.
// - Status bit 9 is a sticky overvoltage flag since the last device status message.
// - Overvoltage disables the coil drivers of both gauges.
// - Status bit 8 is sticky undervoltage; it never disables outputs.
// - Status bit 7 reports clock calibration out of range.
// - Status bit 6 is the OR of sticky under and overvoltage.
// - Status bits 5 and 4 show movement since the last message.
// - Status bits 3 and 2 show zero return, held until the next message unless the run request drops.
// - Status bits 1 and 0 latch overtemperature, disable, clear on re-enable.
// - Accumulator word bit 15 shows any zero return in progress.
// - Accumulator word bits 14 to 0 carry the back-EMF accumulator.
// - The accumulator field reads zero after any reset.
// - The accumulator field holds its last value after a zero return.
// - Chip select falling loads the selected word; shifted out MSB first.
// - Only frames of a nonzero multiple of 16 bits take effect.
// - Supply fault flags clear only after the device word went out validly.
// - Select 1100, 1101 and 111x pick position and velocity words.
`timescale 1ns/1ps
module gauge_status_readout
  import gauge_status_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              srst,
  // Serial pins from the host.
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              sdi,
  // Serial output, enable low while driving.
  output logic                   sdo,
  output logic                   sdo_oe_n,
  // Gauge motion state.
  input  wire logic              gauge1_direction,
  input  wire logic              gauge0_direction,
  input  wire logic              gauge1_zero_side,
  input  wire logic              gauge0_zero_side,
  input  wire logic              gauge1_not_at_target,
  input  wire logic              gauge0_not_at_target,
  input  wire logic              gauge1_step,
  input  wire logic              gauge0_step,
  // Zero return state.
  input  wire logic              gauge1_zero_return_run,
  input  wire logic              gauge0_zero_return_run,
  input  wire logic              gauge1_zero_found,
  input  wire logic              gauge0_zero_found,
  input  wire logic [ACC_W-1:0]  backemf_accumulator,
  input  wire logic              accumulator_update,
  // Other status words, built elsewhere.
  input  wire logic [WORD_W-1:0] gauge0_position_word,
  input  wire logic [WORD_W-1:0] gauge1_position_word,
  input  wire logic [WORD_W-1:0] velocity_word,
  // Supply, clock and temperature monitors.
  input  wire logic              supply_over,
  input  wire logic              supply_under,
  input  wire logic              clock_cal_bad,
  input  wire logic              gauge1_overtemp,
  input  wire logic              gauge0_overtemp,
  // Results toward the rest of the device.
  output logic                   gauge1_enable,
  output logic                   gauge0_enable,
  output logic [WORD_W-1:0]      command_word,
  output logic                   command_valid,
  output logic [SEL_W-1:0]       status_select_field
);

  // Select decoding, used for the load and for deciding which flags a frame clears.
  function automatic logic sel_is_device(input logic [SEL_W-1:0] sel);
    sel_is_device = ~sel[3];
  endfunction

  function automatic logic [WORD_W-1:0] pick_word(input logic [SEL_W-1:0] sel,
                                                  input logic [WORD_W-1:0] dev,
                                                  input logic [WORD_W-1:0] acc,
                                                  input logic [WORD_W-1:0] p0,
                                                  input logic [WORD_W-1:0] p1,
                                                  input logic [WORD_W-1:0] vel);
    if (sel_is_device(sel))
      pick_word = dev;
    else if (!sel[2])
      pick_word = acc;
    else if (sel == SEL_POS0)
      pick_word = p0;
    else if (sel == SEL_POS1)
      pick_word = p1;
    else
      pick_word = vel;
  endfunction

  // Two-flop synchronisers for every pin and monitor from outside mclk.
  // They reset to the pins' idle levels, so no false edge or fault follows a reset.
  localparam int unsigned NSYNC = 14;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;

  assign raw_in = {cs_n, sclk, sdi, supply_over, supply_under, clock_cal_bad,
                   gauge1_overtemp, gauge0_overtemp, gauge1_step, gauge0_step,
                   gauge1_zero_found, gauge0_zero_found,
                   gauge1_zero_return_run, gauge0_zero_return_run};

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  logic cs_s, sclk_s, sdi_s, ov_s, uv_s, cal_s, ot1_s, ot0_s;
  logic step1_s, step0_s, zf1_s, zf0_s, zr1_s, zr0_s;
  assign {cs_s, sclk_s, sdi_s, ov_s, uv_s, cal_s, ot1_s, ot0_s,
          step1_s, step0_s, zf1_s, zf0_s, zr1_s, zr0_s} = sync2_ff;

  // Whole state of the readout in one record.
  typedef struct packed {
    frame_state_e      state;
    logic              cs_d;
    logic              sclk_d;
    logic              step1_d;
    logic              step0_d;
    logic [CNT_W-1:0]  bits;
    logic              bits_nz;
    logic              sent_device;
    logic [SEL_W-1:0]  sel;
    logic              ov;
    logic              uv;
    logic              ot1;
    logic              ot0;
    logic              gauge1_moved_flag;
    logic              gauge0_moved_flag;
    logic              gauge1_zero_return_active;
    logic              gauge0_zero_return_active;
    logic              zf1;
    logic              zf0;
    logic [ACC_W-1:0]  acc;
    logic              en1;
    logic              en0;
    logic              oe_n;
    logic [WORD_W-1:0] cmd;
    logic              cmd_v;
  } readout_s;

  readout_s st_ff;
  readout_s nxt_st;

  logic              cs_fall, cs_rise, sclk_rise, sclk_fall;
  logic [WORD_W-1:0] dev_word, acc_word, rx_word;
  logic              shift_out;

  assign cs_fall   = st_ff.cs_d & ~cs_s;
  assign cs_rise   = ~st_ff.cs_d & cs_s;
  assign sclk_rise = ~st_ff.sclk_d & sclk_s & ~cs_s;
  assign sclk_fall = st_ff.sclk_d & ~sclk_s & ~cs_s;

  // Device status word, live gauge state mixed with the sticky flags.
  assign dev_word = {gauge1_direction, gauge0_direction,
                     gauge1_zero_side, gauge0_zero_side,
                     gauge1_not_at_target, gauge0_not_at_target,
                     st_ff.ov, st_ff.uv,
                     cal_s,
                     st_ff.ov | st_ff.uv,
                     st_ff.gauge1_moved_flag, st_ff.gauge0_moved_flag,
                     st_ff.gauge1_zero_return_active, st_ff.gauge0_zero_return_active,
                     st_ff.ot1, st_ff.ot0};

  assign acc_word = {st_ff.gauge1_zero_return_active | st_ff.gauge0_zero_return_active, st_ff.acc};

  status_shifter u_shift (
    .mclk       (mclk),
    .srst       (srst),
    .load       (cs_fall),
    .load_word  (pick_word(st_ff.sel, dev_word, acc_word, gauge0_position_word,
                           gauge1_position_word, velocity_word)),
    .sample     (sclk_rise),
    .shift      (sclk_fall),
    .serial_in  (sdi_s),
    .serial_out (shift_out),
    .rx_word    (rx_word)
  );

  logic frame_ok;
  logic clear_faults;
  logic cfg_write;
  assign frame_ok     = (st_ff.state == ST_CLOSE) && st_ff.bits_nz && (st_ff.bits == '0);
  assign clear_faults = frame_ok && st_ff.sent_device;
  assign cfg_write    = frame_ok && (rx_word[ADDR_HI:ADDR_LO] == ADDR_GAUGE_CFG);

  // Frame engine, sticky flags and enables in one pass.
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.cs_d    = cs_s;
    nxt_st.sclk_d  = sclk_s;
    nxt_st.step1_d = step1_s;
    nxt_st.step0_d = step0_s;
    nxt_st.cmd_v   = 1'b0;

    unique case (st_ff.state)
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          nxt_st.state       = ST_ACTIVE;
          nxt_st.bits        = '0;
          nxt_st.bits_nz     = 1'b0;
          nxt_st.sent_device = sel_is_device(st_ff.sel);
          nxt_st.oe_n        = 1'b0;
        end
      end
      ST_ACTIVE:
      begin
        if (sclk_rise)
        begin
          nxt_st.bits    = CNT_W'(st_ff.bits + 1'b1) & CNT_W'(WORD_W - 1);
          nxt_st.bits_nz = 1'b1;
        end
        if (cs_rise)
        begin
          nxt_st.state = ST_CLOSE;
          nxt_st.oe_n  = 1'b1;
        end
      end
      ST_CLOSE:
      begin
        nxt_st.state = ST_IDLE;
        if (frame_ok)
        begin
          nxt_st.cmd   = rx_word;
          nxt_st.cmd_v = 1'b1;
        end
        if (cfg_write)
        begin
          nxt_st.sel = rx_word[SEL_HI:SEL_LO];
          nxt_st.en1 = rx_word[CFG_EN1];
          nxt_st.en0 = rx_word[CFG_EN0];
        end
      end
      default:
      begin
        nxt_st.state = ST_IDLE;
      end
    endcase

    // Flags clear after a valid frame; a new event in the same cycle still sets them.
    if (clear_faults)
    begin
      nxt_st.ov = 1'b0;
      nxt_st.uv = 1'b0;
    end
    if (frame_ok)
    begin
      nxt_st.gauge1_moved_flag = 1'b0;
      nxt_st.gauge0_moved_flag = 1'b0;
      if (st_ff.zf1)
        nxt_st.gauge1_zero_return_active = 1'b0;
      if (st_ff.zf0)
        nxt_st.gauge0_zero_return_active = 1'b0;
    end
    if (ov_s)
    begin
      nxt_st.ov  = 1'b1;
      nxt_st.en1 = 1'b0;
      nxt_st.en0 = 1'b0;
    end
    if (uv_s)
      nxt_st.uv = 1'b1;
    if (step1_s != st_ff.step1_d)
      nxt_st.gauge1_moved_flag = 1'b1;
    if (step0_s != st_ff.step0_d)
      nxt_st.gauge0_moved_flag = 1'b1;

    // Zero return activity follows the run request; a found zero waits for a message.
    // The found mark stays until the run request drops, so a held request cannot restart it.
    if (!zr1_s)
    begin
      nxt_st.gauge1_zero_return_active = 1'b0;
      nxt_st.zf1  = 1'b0;
    end
    else if (!st_ff.gauge1_zero_return_active && !st_ff.zf1)
      nxt_st.gauge1_zero_return_active = 1'b1;
    if (!zr0_s)
    begin
      nxt_st.gauge0_zero_return_active = 1'b0;
      nxt_st.zf0  = 1'b0;
    end
    else if (!st_ff.gauge0_zero_return_active && !st_ff.zf0)
      nxt_st.gauge0_zero_return_active = 1'b1;
    if (zf1_s && st_ff.gauge1_zero_return_active)
      nxt_st.zf1 = 1'b1;
    if (zf0_s && st_ff.gauge0_zero_return_active)
      nxt_st.zf0 = 1'b1;

    // Accumulator only moves while a return runs, so it keeps its last result.
    if (accumulator_update && (st_ff.gauge1_zero_return_active | st_ff.gauge0_zero_return_active))
      nxt_st.acc = backemf_accumulator;

    // Overtemperature latches and disables; a re-enable clears it unless it persists.
    if (cfg_write && rx_word[CFG_EN1])
      nxt_st.ot1 = 1'b0;
    if (cfg_write && rx_word[CFG_EN0])
      nxt_st.ot0 = 1'b0;
    if (ot1_s)
    begin
      nxt_st.ot1 = 1'b1;
      nxt_st.en1 = 1'b0;
    end
    if (ot0_s)
    begin
      nxt_st.ot0 = 1'b1;
      nxt_st.en0 = 1'b0;
    end
  end

  // Register the record; reset leaves the device word selected and accumulator clear.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_ff        <= '0;
      st_ff.state  <= ST_IDLE;
      st_ff.cs_d   <= 1'b1;
      st_ff.sel    <= SEL_RESET;
      st_ff.acc    <= ACC_RESET;
      st_ff.oe_n   <= 1'b1;
      st_ff.cmd    <= WORD_ZERO;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // The shifter output is itself a flop; the enable masks it between frames.
  assign sdo                 = shift_out;
  assign sdo_oe_n            = st_ff.oe_n;
  assign gauge1_enable       = st_ff.en1;
  assign gauge0_enable       = st_ff.en0;
  assign command_word        = st_ff.cmd;
  assign command_valid       = st_ff.cmd_v;
  assign status_select_field = st_ff.sel;

endmodule

// ===== gauge_status_readout_chk.sv
// Checker for the gauge status readout: select, enable and serial output timing.
// Assumes one mclk domain with synchronous active-high srst; bound at the foot.
`timescale 1ns/1ps
module gauge_status_readout_chk
  import gauge_status_pkg::*;
(
  // Clock and reset.
  input wire logic              mclk,
  input wire logic              srst,
  // Serial pins.
  input wire logic              cs_n,
  input wire logic              sdo,
  input wire logic              sdo_oe_n,
  // Watched status inputs.
  input wire logic              gauge1_direction,
  input wire logic              gauge0_overtemp,
  input wire logic              supply_over,
  input wire logic [WORD_W-1:0] gauge0_position_word,
  // Results.
  input wire logic              gauge1_enable,
  input wire logic              gauge0_enable,
  input wire logic [WORD_W-1:0] command_word,
  input wire logic              command_valid,
  input wire logic [SEL_W-1:0]  status_select_field
);
  // All checks share mclk and are off while reset is high.
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (srst);

  // The select field moves only with an accepted command.
  a_sel_only_cmd: assert property (!$stable(status_select_field) |-> command_valid)
    else $error("select changed without a command");
  a_sel_from_cmd: assert property (command_valid && command_word[15:13] == 3'h0 |->
    status_select_field == command_word[11:8]) else $error("select differs from command");
  a_cv_after_cs: assert property (command_valid |-> $past(cs_n, 1) && $past(cs_n, 4))
    else $error("command accepted while selected");
  // Faults switch the coil drivers off within a few cycles of the synchroniser.
  a_ov_drv_off: assert property ($rose(supply_over) |-> ##[1:6] (!gauge0_enable && !gauge1_enable))
    else $error("overvoltage left a gauge on");
  a_ot_drv_off: assert property ($rose(gauge0_overtemp) |-> ##[1:6] !gauge0_enable)
    else $error("overtemperature left gauge 0 on");
  a_en_from_cmd: assert property (command_valid && command_word[15:13] == 3'h0 && !supply_over &&
    !gauge0_overtemp |-> gauge0_enable == command_word[0] && gauge1_enable == command_word[4])
    else $error("enables differ from command");
  // The output is driven only inside a frame.
  a_oe_idle: assert property (cs_n [*6] |-> sdo_oe_n)
    else $error("output driven outside a frame");
  a_oe_drive: assert property (!cs_n [*6] |-> !sdo_oe_n)
    else $error("output not driven in a frame");
  a_dev_msb: assert property ($fell(sdo_oe_n) && !status_select_field[3] |-> sdo == gauge1_direction)
    else $error("device word does not start with gauge 1 direction");
  a_pos_msb: assert property ($fell(sdo_oe_n) && status_select_field == SEL_POS0 |->
    sdo == gauge0_position_word[15]) else $error("position word does not start with its MSB");

  // Main scenarios reached.
  c_acc_read: cover property ($fell(sdo_oe_n) && status_select_field[3:2] == 2'b10);
  c_ov_trip: cover property ($fell(gauge0_enable) && supply_over);
  c_cfg_write: cover property (command_valid && command_word[15:13] == 3'h0);
endmodule

bind gauge_status_readout gauge_status_readout_chk i_gauge_status_readout_chk (
  .mclk, .srst, .cs_n, .sdo, .sdo_oe_n, .gauge1_direction, .gauge0_overtemp, .supply_over,
  .gauge0_position_word, .gauge1_enable, .gauge0_enable, .command_word, .command_valid, .status_select_field);

// ===== gauge_status_readout_tb_top.sv
// Self-checking bench for the gauge status readout, driven through the serial host model.
// Assumes the package, the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module gauge_status_readout_tb_top
  import gauge_status_pkg::*;
();
  localparam logic [WORD_W-1:0] P0 = 16'h1234;
  localparam logic [WORD_W-1:0] P1 = 16'h5678;
  localparam logic [WORD_W-1:0] VEL = 16'h9abc;
  // Live gauge levels, gauge 1 before gauge 0: direction, zero side, off target.
  logic [5:0] live = 6'h00;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [ACC_W-1:0] backemf_accumulator = 15'h0000;
  logic cs_n, sclk, sdi, sdo, sdo_oe_n, gauge1_enable, gauge0_enable, command_valid;
  logic gauge1_step, gauge0_step, gauge1_zero_return_run, gauge0_zero_return_run, gauge0_zero_found;
  logic accumulator_update, supply_over, supply_under, clock_cal_bad, gauge0_overtemp;
  logic gauge1_zero_found, gauge1_overtemp;
  logic [WORD_W-1:0] command_word;
  logic [SEL_W-1:0] status_select_field;
  logic [31:0] got;
  logic [15:0] cfg = 16'h0011;
  int err_count = 0;
  int n_tests = 0;
  wire logic gauge1_direction, gauge0_direction, gauge1_zero_side, gauge0_zero_side;
  wire logic gauge1_not_at_target, gauge0_not_at_target;
  assign {gauge1_direction, gauge0_direction, gauge1_zero_side, gauge0_zero_side,
          gauge1_not_at_target, gauge0_not_at_target} = live;

  // Clock, host model and design.
  always #50 mclk = ~mclk;
  spi_host_model i_spi_host_model (.mclk, .sdo, .sdo_oe_n, .cs_n, .sclk, .sdi);
  gauge_status_readout i_gauge_status_readout (
    .mclk, .srst, .cs_n, .sclk, .sdi, .sdo, .sdo_oe_n, .gauge1_direction, .gauge0_direction,
    .gauge1_zero_side, .gauge0_zero_side, .gauge1_not_at_target, .gauge0_not_at_target,
    .gauge1_step, .gauge0_step, .gauge1_zero_return_run, .gauge0_zero_return_run,
    .gauge1_zero_found, .gauge0_zero_found, .backemf_accumulator, .accumulator_update,
    .gauge0_position_word(P0), .gauge1_position_word(P1), .velocity_word(VEL), .supply_over,
    .supply_under, .clock_cal_bad, .gauge1_overtemp, .gauge0_overtemp, .gauge1_enable,
    .gauge0_enable, .command_word, .command_valid, .status_select_field);

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Frame helpers; async inputs are held 8 cycles so the synchronisers see them.
  task automatic hold8();
    repeat (8) @(negedge mclk);
  endtask
  task automatic xfer(input logic [15:0] w);
    i_spi_host_model.frame(16, {16'h0000, w}, got);
  endtask
  task automatic wr(input logic [15:0] w);
    cfg = w;
    xfer(w);
  endtask
  task automatic rd(input logic [15:0] exp);
    xfer(cfg);
    chk(got[15:0], exp);
  endtask
  function automatic logic [15:0] dw(input logic [9:0] f);
    return {live, f};
  endfunction
  // The first wait keeps the pulse a full cycle wide even when called on a falling edge.
  task automatic pulse_acc(input logic [14:0] v);
    @(negedge mclk);
    backemf_accumulator = v;
    accumulator_update = 1'b1;
    @(negedge mclk);
    accumulator_update = 1'b0;
  endtask

  // Reset values, the first words out and the live gauge bits.
  task automatic t_reset();
    chk({status_select_field, gauge1_enable, gauge0_enable, sdo_oe_n}, 7'h01);
    wr(16'h0811);
    chk(got[15:0], dw(10'h000));
    wr(16'h0011);
    chk(got[15:0], 16'h0000);
    live = 6'h2d;
    rd(dw(10'h000));
    live = 6'h12;
    rd(dw(10'h000));
  endtask

  // Every select code, then a foreign command and a short frame.
  task automatic t_select();
    logic [15:0] e;
    for (int s = 0; s < 16; s++)
    begin
      wr({4'h0, s[3:0], 8'h11});
      e = !s[3] ? dw(10'h000) : !s[2] ? 16'h0000 : s[1] ? VEL : s[0] ? P1 : P0;
      chk(status_select_field, s[3:0]);
      rd(e);
    end
    xfer(16'h2e11);
    chk(status_select_field, 4'hf);
    i_spi_host_model.frame(8, 32'h0, got);
    chk(status_select_field, 4'hf);
    wr(16'h0011);
  endtask

  // Supply and clock faults, movement flags and a refused frame.
  task automatic t_supply();
    supply_over = 1'b1;
    hold8();
    supply_over = 1'b0;
    hold8();
    chk({gauge1_enable, gauge0_enable}, 2'b00);
    cfg = 16'h0000;
    i_spi_host_model.frame(8, 32'h0, got);
    rd(dw(10'h240));
    rd(dw(10'h000));
    wr(16'h0011);
    supply_under = 1'b1;
    hold8();
    supply_under = 1'b0;
    chk({gauge1_enable, gauge0_enable}, 2'b11);
    rd(dw(10'h140));
    clock_cal_bad = 1'b1;
    {gauge1_step, gauge0_step} = 2'b11;
    hold8();
    rd(dw(10'h0b0));
    clock_cal_bad = 1'b0;
    hold8();
    rd(dw(10'h000));
  endtask

  // Zero return: activity bits, accumulator capture and hold, flags kept while unread.
  task automatic t_zero();
    gauge0_zero_return_run = 1'b1;
    hold8();
    rd(dw(10'h004));
    pulse_acc(15'h4abc);
    wr(16'h0800);
    rd(16'hcabc);
    gauge0_zero_found = 1'b1;
    hold8();
    rd(16'hcabc);
    rd(16'h4abc);
    {gauge0_zero_found, gauge0_zero_return_run} = 2'b00;
    pulse_acc(15'h1111);
    rd(16'h4abc);
    gauge1_zero_return_run = 1'b1;
    hold8();
    rd(16'hcabc);
    gauge1_zero_found = 1'b1;
    hold8();
    rd(16'hcabc);
    rd(16'h4abc);
    {gauge1_zero_found, gauge1_zero_return_run} = 2'b00;
    supply_over = 1'b1;
    hold8();
    supply_over = 1'b0;
    hold8();
    rd(16'h4abc);
    wr(16'h0000);
    rd(dw(10'h240));
    rd(dw(10'h000));
    wr(16'h0011);
  endtask

  // Overtemperature latch and re-enable, then a chained 32-bit frame.
  task automatic t_temp();
    gauge0_overtemp = 1'b1;
    hold8();
    gauge0_overtemp = 1'b0;
    hold8();
    chk({gauge1_enable, gauge0_enable}, 2'b10);
    wr(16'h0010);
    rd(dw(10'h001));
    wr(16'h0011);
    chk({gauge1_enable, gauge0_enable}, 2'b11);
    rd(dw(10'h000));
    gauge1_overtemp = 1'b1;
    hold8();
    gauge1_overtemp = 1'b0;
    hold8();
    chk({gauge1_enable, gauge0_enable}, 2'b01);
    rd(dw(10'h002));
    rd(dw(10'h000));
    i_spi_host_model.frame(32, 32'h5a5a0011, got);
    chk(got, {dw(10'h000), 16'h5a5a});
    chk(command_word, 16'h0011);
  endtask

  // Main sequence: reset for three cycles, then the scenarios.
  initial
  begin
    {gauge1_step, gauge0_step, gauge1_zero_return_run, gauge0_zero_return_run, gauge0_zero_found} = '0;
    {accumulator_update, supply_over, supply_under, clock_cal_bad, gauge0_overtemp} = '0;
    {gauge1_zero_found, gauge1_overtemp} = '0;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_select();
    t_supply();
    t_zero();
    t_temp();
    // A reset in mid-run must clear select, enables and the held accumulator again.
    {gauge1_step, gauge0_step} = 2'b00;
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    tally_and_finish();
  end

  // Cuts a hung run short; running out counts as a mismatch.
  initial
  begin
    repeat (60000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end
endmodule

// ===== spi_host_model.sv
// Serial host model: drives chip select, link clock and data, and captures the output.
// Assumes a 100 ns mclk; every pin change lands on a falling mclk edge.
`timescale 1ns/1ps
module spi_host_model (
  // Clock for alignment.
  input  wire logic mclk,
  // Serial output of the device and its enable.
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  // Pins toward the device.
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  // The pin floats while not driven, so a stale bit is never read.
  wire logic so_line = sdo_oe_n ? 1'bz : sdo;

  // Idle pins at time zero.
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // One frame of n bits, MSB first; the link clock idles low and stands still between frames.
  // Output bits are read late in the high phase, where they have long settled.
  task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    @(negedge mclk);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = tx[i];
      #400 sclk = 1'b1;
      #300 rx = {rx[30:0], so_line};
      #100 sclk = 1'b0;
    end
    #400 cs_n = 1'b1;
    sdi = ~sdi;
    #1000;
  endtask
endmodule

// ===== status_shifter.sv
// Serial shift register for the status readout: loads a word, shifts it out MSB
// first on the link clock's falling edges and shifts incoming bits in on rising edges.
// Assumes edge strobes already synchronised to mclk by the parent.
`timescale 1ns/1ps
module status_shifter
  import gauge_status_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              srst,
  // Control strobes.
  input  wire logic              load,
  input  wire logic [WORD_W-1:0] load_word,
  input  wire logic              sample,
  input  wire logic              shift,
  input  wire logic              serial_in,
  // Results.
  output logic                   serial_out,
  output logic [WORD_W-1:0]      rx_word
);

  typedef struct packed {
    logic [WORD_W-1:0] tx;
    logic [WORD_W-1:0] rx;
    logic              bit_in;
  } shifter_s;

  shifter_s st_ff;
  shifter_s nxt_st;

  // Bits leaving the transmit side are followed by received bits, so a frame
  // longer than one word echoes what came in, which suits daisy chains.
  always_comb
  begin
    nxt_st = st_ff;
    if (load)
    begin
      nxt_st.tx = load_word;
    end
    if (sample)
    begin
      nxt_st.rx     = {st_ff.rx[WORD_W-2:0], serial_in};
      nxt_st.bit_in = serial_in;
    end
    if (shift && !load)
    begin
      nxt_st.tx = {st_ff.tx[WORD_W-2:0], st_ff.bit_in};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign serial_out = st_ff.tx[WORD_W-1];
  assign rx_word    = st_ff.rx;

endmodule
